// ### spc_map.svh
/*
 * spc_map.svh: offsets, field positions, reset values and timing counts
 * of the stepper pulse controller host port.
 * Assumes inclusion by bare name from the design modules, not from spc_pkg.sv.
 */
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// byte offsets within one axis window
`define SPC_OFS_UPPER 2'h0
`define SPC_OFS_MIDDLE 2'h1
`define SPC_OFS_LOWER 2'h2
`define SPC_OFS_AUX 2'h3
// command codes in the upper byte (high nibble)
`define SPC_CMD_START_MODE 4'h0
`define SPC_CMD_IRQ_CLEAR 4'h1
`define SPC_CMD_REG_SELECT 4'h2
`define SPC_CMD_OUTPUT_MODE 4'h3
`define SPC_CMD_IMM_STOP 4'h4
`define SPC_CMD_DEC_STOP 4'h5
// field positions
`define SPC_BIT_IE_STOP 0
`define SPC_BIT_IE_CMDSTOP 1
`define SPC_BIT_IE_RAMP 0
`define SPC_BIT_IE_EXTGO 1
`define SPC_BIT_PULSE_POL 0
`define SPC_BIT_GPIO_MODE 1
`define SPC_BIT_IRQ_MASK 2
// reset values
`define SPC_RST_BYTE 8'h00
`define SPC_RST_POL 1'b0
// reset hold and access timing
`define SPC_RESET_HOLD_CYC 2'h3
`define SPC_ACCESS_NS 20
`define SPC_CLK_NS 5
`define SPC_ACCESS_CYC ((`SPC_ACCESS_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)

`endif

// ### spc_pkg.sv
/*
 * spc_pkg.sv: types shared by the host port and its axis slice.
 * Assumes spc_map.svh is on the include path.
 */
package spc_pkg;
	typedef logic [7:0] spc_byte_t;
	typedef logic [1:0] spc_axis_t;
	typedef enum logic [1:0] {
		SPC_IDLE = 2'b00,
		SPC_WAIT = 2'b01,
		SPC_DONE = 2'b10
	} spc_acc_t;
endpackage

// ### spc_axis_slice.sv
/*
 * spc_axis_slice.sv: per-axis buffers, mode bits and interrupt request
 * of the stepper pulse controller host port.
 * Assumes strobes arrive as one-cycle pulses in the clk domain.
 */
`timescale 1ns/100ps
`include "spc_map.svh"
module spc_axis_slice
	import spc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_int_n,
	input wire logic wr_pulse,
	input wire logic [1:0] wr_ofs,
	input wire spc_byte_t wr_data,
	input wire logic [1:0] rd_ofs,
	input wire logic ev_stop,
	input wire logic ev_ramp,
	input wire logic ev_extgo,
	output spc_byte_t rd_data,
	output logic irq_req,
	output logic pulse_pol,
	output logic gpio_mode
);
	spc_byte_t wbuf_reg [0:2];
	logic [1:0] ie_start_reg;
	logic [1:0] ie_sel_reg;
	logic [2:0] outmode_reg;
	logic irq_reg;
	logic irq_next;
	logic cmd_issue;
	logic clr_cmd;
	logic cmdstop;
	logic raise;
	logic [3:0] op;

	// upper byte write issues the command in the byte being written
	assign op = wr_data[7:4];
	assign cmd_issue = wr_pulse && wr_ofs == `SPC_OFS_UPPER;
	assign clr_cmd = cmd_issue && op == `SPC_CMD_IRQ_CLEAR;
	assign cmdstop = cmd_issue && (op == `SPC_CMD_IMM_STOP || op == `SPC_CMD_DEC_STOP);
	assign raise = (ev_stop && ie_start_reg[`SPC_BIT_IE_STOP])
		|| (cmdstop && ie_start_reg[`SPC_BIT_IE_CMDSTOP])
		|| (ev_ramp && ie_sel_reg[`SPC_BIT_IE_RAMP])
		|| (ev_extgo && ie_sel_reg[`SPC_BIT_IE_EXTGO]);
	// set wins over the clear so no event is lost
	assign irq_next = raise ? 1'b1 : (clr_cmd ? 1'b0 : irq_reg);
	assign irq_req = irq_reg && !outmode_reg[`SPC_BIT_IRQ_MASK];
	assign pulse_pol = outmode_reg[`SPC_BIT_PULSE_POL];
	assign gpio_mode = outmode_reg[`SPC_BIT_GPIO_MODE];

	// offset 3 reads the main state word: irq and mode bits
	assign rd_data = (rd_ofs == `SPC_OFS_AUX) ? {4'h0, irq_reg, outmode_reg} :
		wbuf_reg[rd_ofs];

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_byte
			always_ff @(posedge clk or negedge rst_int_n) begin
				if (!rst_int_n) begin
					wbuf_reg[i] <= `SPC_RST_BYTE;
				end else if (wr_pulse && wr_ofs == 2'(i)) begin
					wbuf_reg[i] <= wr_data;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			ie_start_reg <= 2'h0;
			ie_sel_reg <= 2'h0;
			outmode_reg <= 3'h0;
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
			if (cmd_issue && op == `SPC_CMD_START_MODE)
				ie_start_reg <= wr_data[1:0];
			if (cmd_issue && op == `SPC_CMD_REG_SELECT)
				ie_sel_reg <= wr_data[1:0];
			if (cmd_issue && op == `SPC_CMD_OUTPUT_MODE)
				outmode_reg <= wr_data[2:0];
		end
	end
endmodule

// ### spc_host_port.sv
/*
 * spc_host_port.sv: host port of a four-axis stepper pulse controller.
 * Assumes an asynchronous 8-bit bus; all pins but ev_stop and ev_ramp are synchronised to clk.
 */
// Behaviour
// - reset holds while resetn low three or more clock cycles.
// - strobes act only while chip select is low.
// - store strobe rising edge captures data into addressed byte.
// - selected fetch drives addressed status or buffer byte.
// - two lowest address bits pick upper, middle or lower byte.
// - address bits two and three pick the target axis.
// - each axis occupies four consecutive byte addresses.
// - data bit zero is least significant, bit seven most.
// - enabled interrupt condition pulls the interrupt output low.
// - interrupt released only by the clearing command.
// - interrupt request can be masked.
// - motor stop raises interrupt when enabled by start mode.
// - immediate or decelerating stop command can raise interrupt.
// - ramp-down start or external start can raise interrupt.
// - interrupt output is open drain for wired OR.
// - hold request low while access needs more time.
// - polarity select low unipolar, high bipolar.
// - polarity select latched when reset releases.
// - phase select low two-phase-on, high half-step.
// - select inputs readable as general-purpose inputs.
// - pulse outputs default active low, polarity configurable.
`timescale 1ns/100ps
`include "spc_map.svh"
module spc_host_port
	import spc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic chip_select_n,
	input wire logic store_strobe_n,
	input wire logic fetch_strobe_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic irq_out_n_o,
	output logic irq_out_n_oe,
	output logic hold_request_n,
	input wire logic polarity_scheme_sel,
	input wire logic phase_pattern_sel,
	input wire logic [3:0] ev_stop,
	input wire logic [3:0] ev_ramp,
	input wire logic [3:0] external_go_n,
	output logic [3:0] bipolar_mode,
	output logic [3:0] half_step_mode,
	output logic [3:0] pulse_active_high
);
	// three-stage synchronisers: index 0 first, 2 third
	logic [1:0] rst_cnt_reg;
	logic rst_int_n;
	logic [2:0] cs_s_reg, wr_s_reg, rd_s_reg;
	logic [2:0] pol_s_reg, ph_s_reg;
	logic [3:0] a_s1_reg, a_s2_reg, a_s3_reg;
	logic [7:0] d_s1_reg, d_s2_reg, d_s3_reg;
	logic [3:0] go_s1_reg, go_s2_reg, go_s3_reg;
	logic wr_lvl_reg, rd_lvl_reg, cs_lvl_reg;
	logic [3:0] go_lvl_reg;
	logic pol_latch_reg;
	logic latched_reg;
	spc_acc_t acc_reg, acc_next;
	logic [2:0] wait_cnt_reg;
	logic [7:0] dout_reg;
	logic wr_rise, go_fall_any;
	logic [3:0] go_fall;
	spc_axis_t axis_sel;
	logic [1:0] ofs;
	spc_byte_t rd_bytes [0:3];
	logic [3:0] irq_req;
	logic [3:0] gpio_mode;
	logic rd_active;

	function automatic logic agree(input logic b2, input logic b3, input logic prev);
		agree = (b2 == b3) ? b3 : prev;
	endfunction

	// reset asserts at once; its release waits for clean clock edges
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rst_cnt_reg <= 2'h0;
		else if (rst_cnt_reg != `SPC_RESET_HOLD_CYC)
			rst_cnt_reg <= rst_cnt_reg + 2'h1;
	end
	logic rst_hold_reg;
	// select pins keep sampling through reset so the latch sees settled levels
	always_ff @(posedge clk) begin
		pol_s_reg <= {pol_s_reg[1:0], polarity_scheme_sel};
		ph_s_reg <= {ph_s_reg[1:0], phase_pattern_sel};
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rst_hold_reg <= 1'b0;
		else if (rst_cnt_reg == `SPC_RESET_HOLD_CYC)
			rst_hold_reg <= 1'b1;
	end
	assign rst_int_n = rst_hold_reg;

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			cs_s_reg <= 3'h7;
			wr_s_reg <= 3'h7;
			rd_s_reg <= 3'h7;
			a_s1_reg <= 4'h0;
			a_s2_reg <= 4'h0;
			a_s3_reg <= 4'h0;
			d_s1_reg <= 8'h00;
			d_s2_reg <= 8'h00;
			d_s3_reg <= 8'h00;
			go_s1_reg <= 4'hF;
			go_s2_reg <= 4'hF;
			go_s3_reg <= 4'hF;
		end else begin
			cs_s_reg <= {cs_s_reg[1:0], chip_select_n};
			wr_s_reg <= {wr_s_reg[1:0], store_strobe_n};
			rd_s_reg <= {rd_s_reg[1:0], fetch_strobe_n};
			a_s1_reg <= addr;
			a_s2_reg <= a_s1_reg;
			a_s3_reg <= a_s2_reg;
			d_s1_reg <= data_in;
			d_s2_reg <= d_s1_reg;
			d_s3_reg <= d_s2_reg;
			go_s1_reg <= external_go_n;
			go_s2_reg <= go_s1_reg;
			go_s3_reg <= go_s2_reg;
		end
	end

	// filtered levels change only when second and third stage agree
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			cs_lvl_reg <= 1'b1;
			wr_lvl_reg <= 1'b1;
			rd_lvl_reg <= 1'b1;
			go_lvl_reg <= 4'hF;
		end else begin
			cs_lvl_reg <= agree(cs_s_reg[1], cs_s_reg[2], cs_lvl_reg);
			wr_lvl_reg <= agree(wr_s_reg[1], wr_s_reg[2], wr_lvl_reg);
			rd_lvl_reg <= agree(rd_s_reg[1], rd_s_reg[2], rd_lvl_reg);
			for (int k = 0; k < 4; k++)
				go_lvl_reg[k] <= agree(go_s2_reg[k], go_s3_reg[k], go_lvl_reg[k]);
		end
	end

	// polarity caught once, first clock after reset release on which stages two and three agree
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			pol_latch_reg <= 1'b0;
			latched_reg <= 1'b0;
		end else if (!latched_reg && pol_s_reg[2] == pol_s_reg[1]) begin
			pol_latch_reg <= pol_s_reg[2];
			latched_reg <= 1'b1;
		end
	end

	// store edge: strobe level goes high while chip select low
	assign wr_rise = !wr_lvl_reg && agree(wr_s_reg[1], wr_s_reg[2], wr_lvl_reg)
		&& !cs_lvl_reg;
	assign go_fall = go_lvl_reg & ~(go_s2_reg & go_s3_reg) & ~(go_s2_reg ^ go_s3_reg);
	assign rd_active = !rd_lvl_reg && !cs_lvl_reg;
	assign axis_sel = a_s3_reg[3:2];
	assign ofs = a_s3_reg[1:0];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_axis
			spc_axis_slice u_axis (
				.clk(clk),
				.rst_int_n(rst_int_n),
				.wr_pulse(wr_rise && axis_sel == 2'(g)),
				.wr_ofs(ofs),
				.wr_data(d_s3_reg),
				.rd_ofs(ofs),
				.ev_stop(ev_stop[g]),
				.ev_ramp(ev_ramp[g]),
				.ev_extgo(go_fall[g]),
				.rd_data(rd_bytes[g]),
				.irq_req(irq_req[g]),
				.pulse_pol(pulse_active_high[g]),
				.gpio_mode(gpio_mode[g])
			);
			assign bipolar_mode[g] = pol_latch_reg;
			assign half_step_mode[g] = ph_s_reg[2];
		end
	endgenerate

	// access sequencer: wait is held until read data has settled
	always_comb begin
		acc_next = acc_reg;
		unique case (acc_reg)
			SPC_IDLE: if (!cs_lvl_reg) acc_next = SPC_WAIT;
			SPC_WAIT: if (wait_cnt_reg == 3'(`SPC_ACCESS_CYC)) acc_next = SPC_DONE;
			SPC_DONE: if (cs_lvl_reg) acc_next = SPC_IDLE;
			default: acc_next = SPC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			acc_reg <= SPC_IDLE;
			wait_cnt_reg <= 3'h0;
			dout_reg <= 8'h00;
		end else begin
			acc_reg <= acc_next;
			wait_cnt_reg <= (acc_reg == SPC_WAIT) ? wait_cnt_reg + 3'h1 : 3'h0;
			// gpio mode exposes the select pins instead of status
			dout_reg <= (gpio_mode[axis_sel] && ofs == `SPC_OFS_AUX) ?
				{6'h00, ph_s_reg[2], pol_s_reg[2]} : rd_bytes[axis_sel];
		end
	end

	assign data_out = dout_reg;
	assign data_oe = rd_active && !fetch_strobe_n && !chip_select_n;
	assign hold_request_n = (acc_reg != SPC_WAIT);
	assign irq_out_n_o = 1'b0;
	assign irq_out_n_oe = |irq_req;
endmodule

// ### spc_host_port_assertions.sv
/*
 * spc_host_port_assertions.sv: checker for the host port pins.
 * Assumes the design's top ports only; bound into spc_host_port below.
 */
`timescale 1ns/100ps
module spc_host_port_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic chip_select_n,
	input wire logic store_strobe_n,
	input wire logic fetch_strobe_n,
	input wire logic data_oe,
	input wire logic irq_out_n_o,
	input wire logic irq_out_n_oe,
	input wire logic hold_request_n,
	input wire logic [3:0] bipolar_mode,
	input wire logic [3:0] pulse_active_high
);
	logic [5:0] since_wr_reg;
	logic [3:0] rel_reg;
	// cycles since a selected store edge; saturates so it never wraps
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			since_wr_reg <= 6'h3F;
			rel_reg <= 4'h0;
		end else begin
			since_wr_reg <= ($rose(store_strobe_n) && !chip_select_n) ? 6'h00 :
				since_wr_reg + {5'h00, since_wr_reg != 6'h3F};
			rel_reg <= rel_reg + {3'h0, rel_reg != 4'hF};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_oe_needs_cs: assert property (chip_select_n |-> !data_oe)
		else $error("data bus driven without chip select");
	chk_oe_needs_fetch: assert property (fetch_strobe_n |-> !data_oe)
		else $error("data bus driven outside a read");
	chk_read_drives: assert property ((!chip_select_n && !fetch_strobe_n)[*8] |-> data_oe)
		else $error("selected read not driven");
	chk_irq_open_drain: assert property (irq_out_n_oe |-> !irq_out_n_o)
		else $error("interrupt pin driven high");
	chk_irq_clear_only: assert property ($fell(irq_out_n_oe) |-> since_wr_reg < 6'd24)
		else $error("interrupt released without a write");
	chk_hold_length: assert property ($fell(hold_request_n) |->
		(!hold_request_n)[*4] ##[1:4] hold_request_n)
		else $error("hold request length wrong");
	chk_reset_quiet: assert property (disable iff (1'b0) !resetn |->
		hold_request_n && !irq_out_n_oe && pulse_active_high == 4'h0)
		else $error("outputs active during reset");
	chk_mode_latched: assert property (rel_reg == 4'hF |-> $stable(bipolar_mode))
		else $error("excitation method changed without reset");
	chk_pol_by_config: assert property ($changed(pulse_active_high) |->
		since_wr_reg < 6'd24)
		else $error("pulse polarity changed without a write");
endmodule
bind spc_host_port spc_host_port_chk u_chk (.clk, .resetn, .chip_select_n, .store_strobe_n,
	.fetch_strobe_n, .data_oe, .irq_out_n_o, .irq_out_n_oe, .hold_request_n, .bipolar_mode,
	.pulse_active_high);

// ### spc_host_bfm.sv
/*
 * spc_host_bfm.sv: host CPU model on the 8-bit asynchronous bus.
 * Assumes the bench's clk; acc is called hierarchically.
 */
`timescale 1ns/100ps
module spc_host_bfm (
	input wire logic clk,
	input wire logic hold_request_n,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	output logic chip_select_n,
	output logic store_strobe_n,
	output logic fetch_strobe_n,
	output logic [3:0] addr,
	output logic [7:0] data_in
);
	logic drv;
	logic [7:0] wd;
	// released bus shows the inverse so a stale byte never matches
	assign data_in = data_oe ? data_out : drv ? wd : ~wd;
	initial begin
		chip_select_n = 1'b1;
		store_strobe_n = 1'b1;
		fetch_strobe_n = 1'b1;
		addr = 4'h0;
		wd = 8'h00;
		drv = 1'b0;
	end
	task automatic acc(input logic wr, input logic csn, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clk);
		#1;
		chip_select_n = csn;
		addr = a;
		wd = d;
		drv = wr;
		@(posedge clk);
		#1;
		store_strobe_n = !wr;
		fetch_strobe_n = wr;
		repeat (4) @(posedge clk);
		#1;
		n = 0;
		while (!hold_request_n && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		repeat (8) @(posedge clk);
		q = data_oe ? data_out : 8'hXX;
		#1;
		store_strobe_n = 1'b1;
		fetch_strobe_n = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chip_select_n = 1'b1;
		drv = 1'b0;
		repeat (12) @(posedge clk);
	endtask
endmodule

// ### testbench.sv
/*
 * testbench.sv: self-checking bench for the stepper pulse host port.
 * Assumes spc_pkg, the design, the host model and the checker compiled first.
 */
`timescale 1ns/100ps
module testbench;
	logic clk, resetn, polarity_scheme_sel, phase_pattern_sel;
	logic chip_select_n, store_strobe_n, fetch_strobe_n, data_oe, hold_request_n;
	logic irq_out_n_o, irq_out_n_oe;
	logic [3:0] addr, ev_stop, ev_ramp, external_go_n;
	logic [3:0] bipolar_mode, half_step_mode, pulse_active_high;
	logic [7:0] data_in, data_out, q;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	wire logic irq_wire = irq_out_n_oe ? irq_out_n_o : 1'b1;
	spc_host_port dut (.clk, .resetn, .chip_select_n, .store_strobe_n, .fetch_strobe_n,
		.addr, .data_in, .data_out, .data_oe, .irq_out_n_o, .irq_out_n_oe, .hold_request_n,
		.polarity_scheme_sel, .phase_pattern_sel, .ev_stop, .ev_ramp, .external_go_n,
		.bipolar_mode, .half_step_mode, .pulse_active_high);
	spc_host_bfm host (.clk, .hold_request_n, .data_out, .data_oe, .chip_select_n,
		.store_strobe_n, .fetch_strobe_n, .addr, .data_in);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic close_out;
		if (n_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_errors++;
			close_out;
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host.acc(1'b1, 1'b0, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a);
		host.acc(1'b0, 1'b0, a, 8'h00, q);
	endtask
	task automatic do_reset(input logic p, input logic h);
		@(posedge clk);
		#1;
		resetn = 1'b0;
		polarity_scheme_sel = p;
		phase_pattern_sel = h;
		repeat (3) @(posedge clk);
		#1;
		resetn = 1'b1;
		repeat (10) @(posedge clk);
	endtask
	task automatic t_reset;
		do_reset(1'b1, 1'b1);
		chk({hold_request_n, irq_wire, data_oe, 1'b0, pulse_active_high}, 8'hC0);
		chk({bipolar_mode, half_step_mode}, 8'hFF);
		#1;
		polarity_scheme_sel = 1'b0;
		repeat (8) @(posedge clk);
		chk({bipolar_mode, half_step_mode}, 8'hFF);
		do_reset(1'b0, 1'b0);
		chk({bipolar_mode, half_step_mode}, 8'h00);
	endtask
	task automatic t_map;
		for (int a = 0; a < 4; a++) begin
			wr(4'(4 * a), 8'h31);
			chk({4'h0, pulse_active_high}, 8'((1 << (a + 1)) - 1));
			rd(4'(4 * a + 3));
			chk(q, 8'h01);
		end
		#1;
		phase_pattern_sel = 1'b1;
		wr(4'h0, 8'h33);
		rd(4'h3);
		chk(q, 8'h02);
		wr(4'h1, 8'h30);
		chk({4'h0, pulse_active_high}, 8'h0F);
		rd(4'h1);
		chk(q, 8'h30);
		host.acc(1'b1, 1'b1, 4'h0, 8'h30, q);
		chk({4'h0, pulse_active_high}, 8'h0F);
		wr(4'h0, 8'h30);
		chk({4'h0, pulse_active_high}, 8'h0E);
	endtask
	task automatic fire(input int k);
		@(posedge clk);
		#1;
		ev_stop = (k == 0) ? 4'h4 : 4'h0;
		ev_ramp = (k == 1) ? 4'h4 : 4'h0;
		external_go_n = (k == 2) ? 4'hB : 4'hF;
		@(posedge clk);
		#1;
		ev_stop = 4'h0;
		ev_ramp = 4'h0;
		if (k > 2) begin
			wr(4'h8, (k == 3) ? 8'h40 : 8'h50);
		end
		repeat (10) @(posedge clk);
		#1;
		external_go_n = 4'hF;
		repeat (8) @(posedge clk);
	endtask
	task automatic t_irq;
		logic [7:0] setup [5] = '{8'h01, 8'h21, 8'h22, 8'h02, 8'h02};
		for (int k = 0; k < 5; k++) begin
			wr(4'h8, setup[k]);
			fire(k);
			chk({7'h00, irq_wire}, 8'h00);
			rd(4'hB);
			chk(q, 8'h09);
			wr(4'h8, 8'h10);
			chk({7'h00, irq_wire}, 8'h01);
		end
		wr(4'h8, 8'h35);
		wr(4'h8, 8'h01);
		fire(0);
		chk({7'h00, irq_wire}, 8'h01);
		rd(4'hB);
		chk(q, 8'h0D);
	endtask
	initial begin
		resetn = 1'b1;
		polarity_scheme_sel = 1'b0;
		phase_pattern_sel = 1'b0;
		ev_stop = 4'h0;
		ev_ramp = 4'h0;
		external_go_n = 4'hF;
		#1;
		resetn = 1'b0;
		t_reset;
		t_map;
		t_irq;
		close_out;
	end
endmodule
